// ===== src/irq_pkg.sv
package irq_pkg;
  localparam int NUM_SRC = 7;
  localparam int ADDR_W = 10;
  // source slots, also the polling order inside one level
  localparam int SRC_PIN0 = 0;
  localparam int SRC_TIMER0 = 1;
  localparam int SRC_PIN1 = 2;
  localparam int SRC_TIMER1 = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_TIMER2 = 5;
  localparam int SRC_COUNTER_ARRAY = 6;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PCON = 8'h87;
  localparam logic [7:0] IDX_SCON = 8'h98;
  localparam logic [7:0] IDX_EN_MASK = 8'ha8;
  localparam logic [7:0] IDX_LVL_HI = 8'hb7;
  localparam logic [7:0] IDX_LVL_LO = 8'hb8;
  localparam logic [7:0] IDX_STAT = 8'hc0;
  localparam logic [7:0] IDX_MASK = 8'hc1;
  localparam logic [7:0] IDX_SVC = 8'hc2;
  // field positions
  localparam int GLOBAL_BIT = 7;
  localparam int IDLE_BIT = 0;
  localparam int TX_FLAG_BIT = 1;
  localparam int RX_FLAG_BIT = 0;
  // reset values and write masks
  localparam logic [7:0] EN_MASK_RST = 8'h00;
  localparam logic [6:0] LVL_LO_RST = 7'h00;
  localparam logic [6:0] LVL_HI_RST = 7'h00;
  localparam logic [7:0] SCON_RST = 8'h00;
  localparam logic [7:0] PCON_RST = 8'h10;
  localparam logic [7:0] PCON_WMASK = 8'hdf;
  // status events
  localparam int EV_W = 4;
  localparam int EV_TAKEN = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_RETI = 2;
  localparam int EV_ORPHAN = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // code addresses per source slot, slot 0 in the low word
  localparam logic [NUM_SRC-1:0][15:0] VEC_TABLE = {
    16'h0033, 16'h002b, 16'h0023, 16'h001b, 16'h0013, 16'h000b, 16'h0003};
endpackage

// ===== src/arb_if.sv
`timescale 1ns/100ps
`default_nettype none
interface arb_if;
  import irq_pkg::*;
  logic [NUM_SRC-1:0] req;
  logic [7:0] en_mask;
  logic [NUM_SRC-1:0] lvl_lo;
  logic [NUM_SRC-1:0] lvl_hi;
  logic [3:0] svc;
  logic [NUM_SRC-1:0][1:0] lvl;
  logic [NUM_SRC-1:0] elig;
  logic svc_any;
  logic [1:0] svc_top;
  logic win_valid;
  logic [2:0] win_idx;
  logic [1:0] win_lvl;
  modport arbiter (input req, en_mask, lvl_lo, lvl_hi, svc,
    output lvl, elig, svc_any, svc_top, win_valid, win_idx, win_lvl);
  modport ctrl (output req, en_mask, lvl_lo, lvl_hi, svc,
    input lvl, elig, svc_any, svc_top, win_valid, win_idx, win_lvl);
endinterface
`default_nettype wire

// ===== src/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;
  sync_t st_r;
  sync_t st_nxt;
  always_comb begin
    st_nxt.meta = d;
    st_nxt.stable = st_r.meta;
    if (!aresetn) begin
      st_nxt.meta = RST_VAL;
      st_nxt.stable = RST_VAL;
    end
  end
  always_ff @(posedge aclk) begin
    st_r <= st_nxt;
  end
  assign q = st_r.stable;
endmodule // pin_sync
`default_nettype wire

// ===== src/prio_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
module prio_arbiter (
  arb_if.arbiter bus
);
  import irq_pkg::*;
  genvar g;
  always_comb begin
    bus.svc_any = |bus.svc;
    bus.svc_top = 2'd0;
    for (int l = 0; l < 4; l++) begin
      if (bus.svc[l]) begin
        bus.svc_top = 2'(l);
      end
    end
  end
  for (g = 0; g < NUM_SRC; g++) begin : g_src
    assign bus.lvl[g] = {bus.lvl_hi[g], bus.lvl_lo[g]};
    assign bus.elig[g] = bus.req[g] && bus.en_mask[g] && bus.en_mask[GLOBAL_BIT]
      && (!bus.svc_any || bus.lvl[g] > bus.svc_top);
  end
  // ascending scan with strict compare keeps the lowest slot on a tie
  always_comb begin
    bus.win_valid = 1'b0;
    bus.win_idx = 3'd0;
    bus.win_lvl = 2'd0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (bus.elig[i] && (!bus.win_valid || bus.lvl[i] > bus.win_lvl)) begin
        bus.win_valid = 1'b1;
        bus.win_idx = 3'(i);
        bus.win_lvl = bus.lvl[i];
      end
    end
  end
endmodule // prio_arbiter
`default_nettype wire

// ===== src/irq_controller.sv
// How it works
// - seven sources: two pins, three timers, serial port, counter array
// - global gate bit 7 of enable register blocks all requests when zero
// - enables: array 6, timer2 5, serial 4, timer1 3, pin1 2, timer0 1, pin0 0
// - level is high bit from high register, low bit from low register
// - only a strictly higher level preempts; level 3 is never preempted
// - simultaneous requests of different levels: higher level served first
// - ties inside a level broken by a fixed polling sequence
// - polling order pin0, timer0, pin1, timer1, serial, timer2, counter array
// - counter array vectors to 0033h, others keep the classic addresses
// - low priority register uses enable bit positions; bit 7 reserved
// - high priority register mirrors low register positions; bit 7 reserved
// - idle bit cleared by hardware when an eligible request wins arbitration, or on reset
// - transmit flag set by hardware, held until software clears it
// - receive flag set by hardware, cleared only by software writing zero
// - serial request is rx or tx; timer2 request is overflow or capture flag
// - after the handler, the core resumes after the idle-entry instruction
`timescale 1ns/100ps
`default_nettype none
module irq_controller (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [irq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [irq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pin_request_0_n,
  input wire logic pin_request_1_n,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  input wire logic timer2_capture_reload_flag,
  input wire logic counter_array_req,
  input wire logic tx_done_set,
  input wire logic rx_done_set,
  output logic vector_req,
  output logic [15:0] vector_addr,
  input wire logic vector_ack,
  input wire logic handler_return,
  output logic sleep_cpu_bit,
  output logic irq
);
  import irq_pkg::*;

  typedef struct packed {
    logic [7:0] en_mask;
    logic [6:0] lvl_lo;
    logic [6:0] lvl_hi;
    logic [7:0] scon;
    logic [7:0] pcon;
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic [3:0] svc;
    logic req;
    logic [2:0] idx;
    logic [1:0] lvl;
    logic [15:0] vec;
    logic irq;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_en;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [1:0] pins_n;
  logic [EV_W-1:0] ev;
  logic [7:0] wr_idx;
  logic [31:0] rd_data;
  logic rd_ok;
  logic scon_we;
  logic [3:0] svc_work;

  arb_if u_if ();

  // pins come from outside the clock domain; idle level is high
  pin_sync #(
    .WIDTH(2),
    .RST_VAL(2'h3)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({pin_request_1_n, pin_request_0_n}),
    .q(pins_n)
  );

  prio_arbiter u_arb (
    .bus(u_if.arbiter)
  );

  // request vector in polling order
  assign u_if.req = {counter_array_req,
    timer2_overflow | timer2_capture_reload_flag,
    st_r.scon[RX_FLAG_BIT] | st_r.scon[TX_FLAG_BIT],
    timer1_overflow, ~pins_n[1], timer0_overflow, ~pins_n[0]};
  assign u_if.en_mask = st_r.en_mask;
  assign u_if.lvl_lo = st_r.lvl_lo;
  assign u_if.lvl_hi = st_r.lvl_hi;
  assign u_if.svc = st_r.svc;

  always_comb begin
    st_nxt = st_r;
    ev = '0;
    wr_idx = st_r.aw_addr[ADDR_W-1:2];
    scon_we = 1'b0;
    svc_work = st_r.svc;
    rd_ok = 1'b1;
    rd_data = 32'h0;
    // reserved bits read as zero
    case (s_axi_araddr[ADDR_W-1:2])
      IDX_EN_MASK: rd_data = {24'h0, st_r.en_mask};
      IDX_LVL_LO: rd_data = {25'h0, st_r.lvl_lo};
      IDX_LVL_HI: rd_data = {25'h0, st_r.lvl_hi};
      IDX_SCON: rd_data = {24'h0, st_r.scon};
      IDX_PCON: rd_data = {24'h0, st_r.pcon};
      IDX_STAT: rd_data = {28'h0, st_r.stat};
      IDX_MASK: rd_data = {28'h0, st_r.mask};
      IDX_SVC: rd_data = {24'h0, st_r.req, st_r.lvl, 1'b0, st_r.svc};
      default: rd_ok = 1'b0;
    endcase
    // write address and data are taken independently
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = s_axi_wdata[7:0];
      st_nxt.w_en = s_axi_wstrb[0];
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      case (wr_idx)
        IDX_EN_MASK: begin
          if (st_r.w_en) st_nxt.en_mask = st_r.w_data;
        end
        IDX_LVL_LO: begin
          if (st_r.w_en) st_nxt.lvl_lo = st_r.w_data[6:0];
        end
        IDX_LVL_HI: begin
          if (st_r.w_en) st_nxt.lvl_hi = st_r.w_data[6:0];
        end
        IDX_SCON: begin
          scon_we = st_r.w_en;
          if (st_r.w_en) st_nxt.scon = st_r.w_data;
        end
        IDX_PCON: begin
          if (st_r.w_en) st_nxt.pcon = st_r.w_data & PCON_WMASK;
        end
        IDX_STAT: begin
          if (st_r.w_en) st_nxt.stat = st_r.stat & ~st_r.w_data[EV_W-1:0];
        end
        IDX_MASK: begin
          if (st_r.w_en) st_nxt.mask = st_r.w_data[EV_W-1:0];
        end
        IDX_SVC: begin
          st_nxt.bresp = RESP_OKAY;
        end
        default: begin
          st_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_data;
      st_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    st_nxt.arready = !st_nxt.rvalid;
    // serial flags: a hardware set beats a software clear in the same cycle
    if (tx_done_set) st_nxt.scon[TX_FLAG_BIT] = 1'b1;
    if (rx_done_set) st_nxt.scon[RX_FLAG_BIT] = 1'b1;
    // return releases the top level before a new level is pushed
    if (handler_return) begin
      if (u_if.svc_any) begin
        svc_work[u_if.svc_top] = 1'b0;
        ev[EV_RETI] = 1'b1;
      end else begin
        ev[EV_ORPHAN] = 1'b1;
      end
    end
    if (st_r.req && vector_ack) begin
      svc_work[st_r.lvl] = 1'b1;
      st_nxt.req = 1'b0;
      ev[EV_TAKEN] = 1'b1;
    end else begin
      // offer follows the arbiter until the core takes it
      st_nxt.req = u_if.win_valid;
      st_nxt.idx = u_if.win_idx;
      st_nxt.lvl = u_if.win_lvl;
      st_nxt.vec = VEC_TABLE[u_if.win_idx];
    end
    st_nxt.svc = svc_work;
    // wake beats a software write that sets idle in the same cycle
    if (u_if.win_valid) begin
      if (st_r.pcon[IDLE_BIT]) ev[EV_WAKE] = 1'b1;
      st_nxt.pcon[IDLE_BIT] = 1'b0;
    end
    st_nxt.stat = st_nxt.stat | ev;
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
    if (!aresetn) begin
      st_nxt = '0;
      st_nxt.en_mask = EN_MASK_RST;
      st_nxt.lvl_lo = LVL_LO_RST;
      st_nxt.lvl_hi = LVL_HI_RST;
      st_nxt.scon = SCON_RST;
      st_nxt.pcon = PCON_RST;
      st_nxt.awready = 1'b1;
      st_nxt.wready = 1'b1;
      st_nxt.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    st_r <= st_nxt;
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign vector_req = st_r.req;
  assign vector_addr = st_r.vec;
  assign sleep_cpu_bit = st_r.pcon[IDLE_BIT];
  assign irq = st_r.irq;

  // helper logic read only by the checks below
  logic higher_pending;
  logic tie_before;
  always_comb begin
    higher_pending = 1'b0;
    tie_before = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (u_if.elig[i] && u_if.lvl[i] > u_if.win_lvl) higher_pending = 1'b1;
      if (u_if.elig[i] && u_if.lvl[i] == u_if.win_lvl && 3'(i) < u_if.win_idx) begin
        tie_before = 1'b1;
      end
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_GLOBAL_GATE: assert property (
    !st_r.en_mask[GLOBAL_BIT] && !(st_r.req && vector_ack) |=> !vector_req)
    else $error("vector offered while global gate is off");
  AST_SOURCE_ENABLE: assert property (
    u_if.win_valid |-> st_r.en_mask[u_if.win_idx] && u_if.req[u_if.win_idx])
    else $error("winner not enabled or not pending");
  AST_ABOVE_SERVICE: assert property (
    u_if.win_valid && u_if.svc_any |-> u_if.win_lvl > u_if.svc_top)
    else $error("winner not above the levels in service");
  AST_LEVEL3_ALONE: assert property (
    st_r.svc[3] |-> !u_if.win_valid)
    else $error("level 3 handler was preempted");
  AST_HIGHER_FIRST: assert property (
    u_if.win_valid |-> !higher_pending)
    else $error("a higher level request was passed over");
  AST_POLL_ORDER: assert property (
    u_if.win_valid |-> !tie_before)
    else $error("polling order broken inside a level");
  AST_ARRAY_VECTOR: assert property (
    vector_req && st_r.idx == 3'(SRC_COUNTER_ARRAY) |-> vector_addr == 16'h0033)
    else $error("counter array vector wrong");
  AST_IDLE_CLEAR: assert property (
    u_if.win_valid |=> !sleep_cpu_bit ##1 vector_req || !sleep_cpu_bit)
    else $error("idle bit not cleared by a taken interrupt");
  AST_TX_SET: assert property (
    tx_done_set |=> st_r.scon[TX_FLAG_BIT])
    else $error("transmit flag not set");
  AST_RX_STICKY: assert property (
    st_r.scon[RX_FLAG_BIT] && !scon_we |=> st_r.scon[RX_FLAG_BIT])
    else $error("receive flag dropped without software");
  AST_SERIAL_OR: assert property (
    u_if.req[SRC_SERIAL] == (st_r.scon[RX_FLAG_BIT] || st_r.scon[TX_FLAG_BIT]))
    else $error("serial request is not the or of its flags");
  AST_RETI_RELEASE: assert property (
    handler_return && u_if.svc_any && !(st_r.req && vector_ack)
      |=> !st_r.svc[$past(u_if.svc_top)])
    else $error("top level not released on return");
  AST_ACK_PUSH: assert property (
    vector_req && vector_ack |=> st_r.svc[$past(st_r.lvl)] && !vector_req)
    else $error("taken level not recorded");
  AST_GATE_OFF: assert property (
    !st_r.en_mask[GLOBAL_BIT] |-> !u_if.win_valid)
    else $error("winner chosen while global gate is off");
  AST_LEVEL_MAP: assert property (
    u_if.win_valid |-> u_if.win_lvl == {st_r.lvl_hi[u_if.win_idx], st_r.lvl_lo[u_if.win_idx]})
    else $error("winner level does not match its priority bits");
  AST_OFFER_ABOVE: assert property (
    vector_req && u_if.svc_any |-> st_r.lvl > u_if.svc_top)
    else $error("offer not above the levels in service");
  AST_IDLE_WAKE: assert property (
    u_if.win_valid |=> !sleep_cpu_bit)
    else $error("idle bit still set after a pending interrupt");

  COV_NESTED: cover property (st_r.svc[0] && vector_req && vector_ack && st_r.lvl != 2'd0);
  COV_TIE: cover property (u_if.win_valid && u_if.elig != (u_if.elig & -u_if.elig));
  COV_WAKE: cover property (sleep_cpu_bit && u_if.win_valid ##1 !sleep_cpu_bit);
  COV_RETURN: cover property (handler_return && u_if.svc_any);
endmodule // irq_controller
`default_nettype wire

// ===== tb/core_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input wire logic aclk,
  input wire logic vector_req,
  input wire logic [15:0] vector_addr,
  output logic vector_ack,
  output logic handler_return
);
  int ack_delay = 0;
  initial begin
    vector_ack = 1'b0;
    handler_return = 1'b0;
  end
  // address taken at the ack edge: a better winner may replace the offer before it
  task automatic take(output logic [15:0] a);
    @(posedge aclk);
    while (vector_req !== 1'b1) @(posedge aclk);
    repeat (ack_delay) @(posedge aclk);
    vector_ack <= 1'b1;
    @(posedge aclk);
    a = vector_addr;
    vector_ack <= 1'b0;
  endtask
  task automatic ret();
    @(posedge aclk);
    handler_return <= 1'b1;
    @(posedge aclk);
    handler_return <= 1'b0;
  endtask
endmodule // core_model
`default_nettype wire

// ===== tb/four_level_interrupt_controller_tb.sv
`timescale 1ns/100ps
`default_nettype none
module four_level_interrupt_controller_tb;
  import irq_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, vreq, vack, hret, sleep, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [7:0] rdv;
  logic [15:0] vaddr;
  logic p0n = 1'b1, p1n = 1'b1, t0 = 1'b0, t1 = 1'b0, t2 = 1'b0, t2c = 1'b0;
  logic ca = 1'b0, txs = 1'b0, rxs = 1'b0;
  int err_total = 0, cmp_count = 0, seed = 32'hdccf;
  bit alt = 1'b0;
  initial begin
    forever #50 aclk = ~aclk;
  end
  irq_controller dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_request_0_n(p0n), .pin_request_1_n(p1n),
    .timer0_overflow(t0), .timer1_overflow(t1), .timer2_overflow(t2),
    .timer2_capture_reload_flag(t2c), .counter_array_req(ca), .tx_done_set(txs),
    .rx_done_set(rxs), .vector_req(vreq), .vector_addr(vaddr), .vector_ack(vack),
    .handler_return(hret), .sleep_cpu_bit(sleep), .irq(irq));
  core_model core (.aclk(aclk), .vector_req(vreq), .vector_addr(vaddr),
    .vector_ack(vack), .handler_return(hret));
  task automatic summarize();
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t reg got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_vec(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t vector got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t flag got %b exp %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bit a, w;
    a = 1'b0;
    w = 1'b0;
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (!a && awready === 1'b1) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
  endtask
  task automatic rdr(input logic [7:0] i);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rdv = rdata[7:0];
    rsp = rresp;
  endtask
  task automatic chk(input logic [7:0] i, input logic [7:0] e, input logic [7:0] m);
    rdr(i);
    cmp_reg(rdv & m, e);
  endtask
  task automatic lv(input logic [6:0] lo, input logic [6:0] hi);
    wr(IDX_LVL_LO, {1'b0, lo});
    wr(IDX_LVL_HI, {1'b0, hi});
  endtask
  // serial flags are sticky, so dropping the serial request needs a register write
  task automatic set_src(input logic [6:0] v);
    p0n <= ~v[0];
    t0 <= v[1];
    p1n <= ~v[2];
    t1 <= v[3];
    t2 <= v[5] & ~alt;
    t2c <= v[5] & alt;
    ca <= v[6];
    if (v[4]) begin
      txs <= alt;
      rxs <= ~alt;
      @(posedge aclk);
      txs <= 1'b0;
      rxs <= 1'b0;
    end else begin
      wr(IDX_SCON, 8'h00);
    end
    repeat (4) @(posedge aclk);
  endtask
  task automatic tk(input logic [15:0] e);
    logic [15:0] a;
    core.take(a);
    cmp_vec(a, e);
  endtask
  task automatic none_for(input int n);
    logic s;
    s = 1'b0;
    repeat (n) begin
      @(posedge aclk);
      s = s | vreq;
    end
    cmp_bit(s, 1'b0);
  endtask
  function automatic int exp_win(logic [6:0] q, logic [7:0] e, logic [6:0] lo, logic [6:0] hi);
    int w, b;
    w = 7;
    b = -1;
    for (int k = 0; k < 7; k++) begin
      if (q[k] && e[7] && e[k] && int'({hi[k], lo[k]}) > b) begin
        w = k;
        b = int'({hi[k], lo[k]});
      end
    end
    return w;
  endfunction
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    summarize();
  end
  initial begin
    logic [6:0] q, lo, hi;
    logic [7:0] e;
    int w;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(IDX_EN_MASK, 8'h00, 8'hff);
    chk(IDX_LVL_LO, 8'h00, 8'hff);
    chk(IDX_LVL_HI, 8'h00, 8'hff);
    chk(IDX_PCON, 8'h10, 8'hff);
    wr(IDX_LVL_LO, 8'hff);
    chk(IDX_LVL_LO, 8'h7f, 8'hff);
    wr(IDX_LVL_HI, 8'hff);
    chk(IDX_LVL_HI, 8'h7f, 8'hff);
    rdr(8'h10);
    cmp_reg({6'h0, rsp}, 8'h02);
    wr(8'h11, 8'h55);
    cmp_reg({6'h0, rsp}, 8'h02);
    // a write with the low byte lane off must leave the register alone
    wstrb <= 4'h0;
    wr(IDX_EN_MASK, 8'h55);
    wstrb <= 4'hf;
    chk(IDX_EN_MASK, 8'h00, 8'hff);
    lv(7'h00, 7'h00);
    set_src(7'h10);
    chk(IDX_SCON, 8'h01, 8'h03);
    alt = 1'b1;
    set_src(7'h10);
    chk(IDX_SCON, 8'h03, 8'h03);
    set_src(7'h00);
    chk(IDX_SCON, 8'h00, 8'h03);
    wr(IDX_EN_MASK, 8'h7f);
    q = 7'h7f;
    set_src(q);
    none_for(8);
    wr(IDX_EN_MASK, 8'hff);
    for (int k = 0; k < 7; k++) begin
      tk(16'h0003 + 16'(k * 8));
      q[k] = 1'b0;
      set_src(q);
      core.ret();
    end
    // levels: pin0/timer0 at 1, pin1 at 2, timer1 and serial at 3
    lv(7'h1b, 7'h1c);
    set_src(7'h01);
    tk(16'h0003);
    set_src(7'h03);
    none_for(5);
    set_src(7'h07);
    tk(16'h0013);
    set_src(7'h0f);
    tk(16'h001b);
    set_src(7'h1f);
    none_for(5);
    chk(IDX_SVC, 8'h0e, 8'h0f);
    set_src(7'h17);
    core.ret();
    tk(16'h0023);
    set_src(7'h00);
    repeat (3) core.ret();
    chk(IDX_SVC, 8'h00, 8'h0f);
    lv(7'h00, 7'h00);
    wr(IDX_STAT, 8'hff);
    wr(IDX_MASK, 8'h03);
    wr(IDX_EN_MASK, 8'h82);
    wr(IDX_PCON, 8'h11);
    cmp_bit(sleep, 1'b1);
    cmp_bit(irq, 1'b0);
    set_src(7'h02);
    cmp_bit(sleep, 1'b0);
    tk(16'h000b);
    @(posedge aclk);
    cmp_bit(irq, 1'b1);
    chk(IDX_STAT, 8'h03, 8'h03);
    wr(IDX_STAT, 8'h03);
    @(posedge aclk);
    cmp_bit(irq, 1'b0);
    set_src(7'h00);
    core.ret();
    repeat (2) @(posedge aclk);
    chk(IDX_STAT, 8'h04, 8'h0f);
    cmp_bit(irq, 1'b0);
    // a return with nothing in service only records the stray event
    core.ret();
    repeat (2) @(posedge aclk);
    chk(IDX_STAT, 8'h0c, 8'h0f);
    chk(IDX_SVC, 8'h00, 8'h0f);
    for (int n = 0; n < 30; n++) begin
      e = 8'h80 | 8'($random(seed));
      lo = 7'($random(seed));
      hi = 7'($random(seed));
      q = (n == 0) ? 7'h7f : 7'($random(seed));
      alt = 1'($random(seed));
      core.ack_delay = $random(seed) & 3;
      lv(lo, hi);
      wr(IDX_EN_MASK, e);
      set_src(q);
      w = exp_win(q, e, lo, hi);
      if (w < 7) tk(16'h0003 + 16'(w * 8));
      else none_for(4);
      set_src(7'h00);
      if (w < 7) core.ret();
    end
    summarize();
  end
endmodule // four_level_interrupt_controller_tb
`default_nettype wire
